// ### core/edge_step_if.sv
/*
  carrier between the configuration block and its edge stepper.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface edge_step_if;
  logic       start;
  logic       carrier_tick;
  logic       double_len;
  logic [4:0] state_count;
  logic       busy;
  logic [4:0] step_index;
  logic       done;

  modport ctl     (output start, carrier_tick, double_len, state_count,
                   input busy, step_index, done);
  modport stepper (input start, carrier_tick, double_len, state_count,
                   output busy, step_index, done);
endinterface : edge_step_if

`default_nettype wire

// ### core/edge_stepper.sv
/*
  walks the transition states of one edge, one or two carrier cycles each.
  assumes carrier_tick is a one-cycle pulse per carrier cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module edge_stepper
  import tx_shaping_pkg::*;
(
  // clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // control
  edge_step_if.stepper st
);

  step_state_t state;
  step_state_t next_state;
  logic        dbl;
  logic [4:0]  last_index;
  logic        last_state;
  logic        advance;
  logic [1:0]  tick_in_state;

  assign last_state = (st.step_index == last_index);
  assign advance    = st.carrier_tick && ((state == ST_SECOND) || (state == ST_FIRST && !dbl));
  assign st.busy    = (state != ST_IDLE);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:   if (st.start && st.state_count != 5'h00) next_state = ST_FIRST;
      ST_FIRST:  if (st.carrier_tick) next_state = dbl ? ST_SECOND : (last_state ? ST_IDLE : ST_FIRST);
      ST_SECOND: if (st.carrier_tick) next_state = last_state ? ST_IDLE : ST_FIRST;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state         <= ST_IDLE;
      dbl           <= 1'b0;
      last_index    <= 5'h00;
      st.step_index <= 5'h00;
      st.done       <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      st.done <= advance && last_state;
      if (state == ST_IDLE && st.start)
      begin
        dbl           <= st.double_len;
        last_index    <= st.state_count - 5'h01;
        st.step_index <= 5'h00;
      end
      else if (advance && !last_state)
        st.step_index <= st.step_index + 5'h01;
    end
  end

  // helper: carrier ticks seen in the current state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_in_state <= 2'h0;
    else if (advance || state == ST_IDLE)
      tick_in_state <= 2'h0;
    else if (st.carrier_tick)
      tick_in_state <= tick_in_state + 2'h1;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_step_moves;
    st.busy && advance && !last_state;
  endsequence

  chk_state_ticks: assert property (
    st.busy && advance |-> (tick_in_state + 2'h1) == (dbl ? CYC_DOUBLE : CYC_SINGLE))
    else $error("transition state length differs from duration setting");

  chk_state_count: assert property (
    st.done |-> $past(st.step_index) == last_index && !st.busy)
    else $error("edge ended on the wrong transition state");

  chk_step_advance: assert property (
    s_step_moves |=> st.step_index == $past(st.step_index) + 5'h01)
    else $error("transition state index skipped");

endmodule : edge_stepper

`default_nettype wire

// ### core/tx_edge_shaping_config.sv
/*
  type A transmit edge shaping configuration: axi4-lite register file,
  decode of edge kinds and profiles for both rates, and the edge stepper.
  assumes a single clock; edge_kind_106k and carrier_tick come from
  logic synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module tx_edge_shaping_config
  import tx_shaping_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // configuration held outside this block
  input  wire logic [7:0]        edge_kind_106k,
  // edge timing
  input  wire logic              type_a_212k_rate,
  input  wire logic              edge_start,
  input  wire logic              carrier_tick,
  // decoded edge settings, one lane per edge_sel_t
  output logic [3:0]             fw_ramp,
  output logic [7:0]             ramp_count,
  output logic [11:0]            time_const,
  output logic [3:0]             lut_mode,
  output logic [3:0]             pa_supply_adapt,
  output logic [3:0]             pa_supply_correct,
  output logic [7:0]             lut_index,
  output logic [3:0]             kind_invalid,
  // modulation level and edge progress
  output logic [7:0]             residual_level_212k,
  output logic                   edge_busy,
  output logic [4:0]             edge_state,
  output logic                   edge_done
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] edge_profile_cfg_106k;
  logic [7:0] edge_duration_cfg_106k;
  logic [7:0] modulation_depth_212k;
  logic [7:0] edge_kind_sel_212k;
  logic [7:0] edge_profile_cfg_212k;

  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic              wr_hit;
  logic [7:0]        wr_idx;
  logic [7:0]        rd_idx;
  logic              rd_hit;
  logic [31:0]       rd_word;
  logic [31:0]       status_word;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx        = aw_addr[9:2];
  assign rd_idx        = s_axi_araddr[9:2];
  assign wr_hit        = (aw_addr[ADDR_W-1:10] == '0) && (wr_idx >= IDX_PROFILE_106K) && (wr_idx <= IDX_PROFILE_212K);
  assign rd_hit        = (s_axi_araddr[ADDR_W-1:10] == '0)
                         && (((rd_idx >= IDX_PROFILE_106K) && (rd_idx <= IDX_PROFILE_212K)) || rd_idx == IDX_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // reserved bits are dropped on write and read back as zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      edge_profile_cfg_106k  <= RST_PROFILE_106K;
      edge_duration_cfg_106k <= RST_DURATION_106K;
      modulation_depth_212k  <= RST_DEPTH_212K;
      edge_kind_sel_212k     <= RST_KIND_212K;
      edge_profile_cfg_212k  <= RST_PROFILE_212K;
    end
    else if (do_write && wr_hit && w_strb[0])
    begin
      case (wr_idx)
        IDX_PROFILE_106K:  edge_profile_cfg_106k  <= w_data[7:0] & PROFILE_MASK;
        IDX_DURATION_106K: edge_duration_cfg_106k <= w_data[7:0] & DURATION_MASK;
        IDX_DEPTH_212K:    modulation_depth_212k  <= w_data[7:0];
        IDX_KIND_212K:     edge_kind_sel_212k     <= w_data[7:0];
        IDX_PROFILE_212K:  edge_profile_cfg_212k  <= w_data[7:0] & PROFILE_MASK;
        default:           edge_kind_sel_212k     <= edge_kind_sel_212k;
      endcase
    end
  end

  assign status_word = {20'h00000, kind_invalid, edge_busy, 2'b00, edge_state};

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (rd_idx)
      IDX_PROFILE_106K:  rd_word[7:0] = edge_profile_cfg_106k;
      IDX_DURATION_106K: rd_word[7:0] = edge_duration_cfg_106k;
      IDX_DEPTH_212K:    rd_word[7:0] = modulation_depth_212k;
      IDX_KIND_212K:     rd_word[7:0] = edge_kind_sel_212k;
      IDX_PROFILE_212K:  rd_word[7:0] = edge_profile_cfg_212k;
      IDX_STATUS:        rd_word      = status_word;
      default:           rd_word      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_word : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge kind and profile decode, one lane per edge
  logic [15:0] kind_code;
  logic [11:0] prof_field;

  assign kind_code  = {edge_kind_sel_212k[RISE_KIND_LSB +: 4], edge_kind_sel_212k[FALL_KIND_LSB +: 4],
                       edge_kind_106k[RISE_KIND_LSB +: 4], edge_kind_106k[FALL_KIND_LSB +: 4]};
  assign prof_field = {edge_profile_cfg_212k[RISE_PROF_LSB +: 3], edge_profile_cfg_212k[FALL_PROF_LSB +: 3],
                       edge_profile_cfg_106k[RISE_PROF_LSB +: 3], edge_profile_cfg_106k[FALL_PROF_LSB +: 3]};

  genvar e;
  generate
    for (e = 0; e < 4; e++)
    begin : g_edge
      logic [3:0] code;
      logic [2:0] field;
      logic       is_fw;
      logic       is_lut;
      assign code   = kind_code[4*e +: 4];
      assign field  = prof_field[3*e +: 3];
      assign is_fw  = (code >= KIND_RAMP_ONE) && (code <= KIND_RAMP_THREE);
      assign is_lut = (code >= KIND_LUT_FIXED) && (code <= KIND_LUT_ADAPT_NOCORR);

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          fw_ramp[e]           <= 1'b0;
          ramp_count[2*e +: 2] <= 2'h0;
          time_const[3*e +: 3] <= 3'h0;
          lut_mode[e]          <= 1'b0;
          pa_supply_adapt[e]   <= 1'b0;
          pa_supply_correct[e] <= 1'b0;
          lut_index[2*e +: 2]  <= 2'h0;
          kind_invalid[e]      <= 1'b0;
        end
        else
        begin
          fw_ramp[e]           <= is_fw;
          ramp_count[2*e +: 2] <= is_fw ? code[1:0] : 2'h0;
          time_const[3*e +: 3] <= is_fw ? field : 3'h0;
          lut_mode[e]          <= is_lut;
          pa_supply_adapt[e]   <= (code == KIND_LUT_ADAPT_CORR) || (code == KIND_LUT_ADAPT_NOCORR);
          pa_supply_correct[e] <= (code == KIND_LUT_ADAPT_CORR);
          lut_index[2*e +: 2]  <= is_lut ? field[1:0] : 2'h0;
          kind_invalid[e]      <= !is_fw && !is_lut;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // residual level and edge stepper
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      residual_level_212k <= RST_DEPTH_212K;
    else
      residual_level_212k <= modulation_depth_212k;
  end

  edge_step_if step_bus ();

  assign step_bus.start        = edge_start;
  assign step_bus.carrier_tick = carrier_tick;
  assign step_bus.double_len   = edge_duration_cfg_106k[DUR_DOUBLE_BIT];
  assign step_bus.state_count  = edge_duration_cfg_106k[DUR_COUNT_LSB +: 5];
  assign edge_busy             = step_bus.busy;
  assign edge_state            = step_bus.step_index;
  assign edge_done             = step_bus.done;

  edge_stepper u_stepper
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .st      (step_bus.stepper)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_fall_ramp_count: assert property (
    (kind_code[3:0] >= KIND_RAMP_ONE && kind_code[3:0] <= KIND_RAMP_THREE)
    |=> fw_ramp[0] && ramp_count[1:0] == $past(kind_code[1:0]) && !lut_mode[0])
    else $error("falling ramp count not taken from edge kind");

  chk_lut_fixed: assert property (
    kind_code[15:12] == KIND_LUT_FIXED |=> lut_mode[3] && !pa_supply_adapt[3] && !pa_supply_correct[3])
    else $error("fixed table edge shows supply adaptation");

  chk_lut_adapt: assert property (
    kind_code[7:4] == KIND_LUT_ADAPT_NOCORR |=> pa_supply_adapt[1] && !pa_supply_correct[1] && lut_mode[1])
    else $error("adaptive table edge without correction misdecoded");

  chk_rise_indep: assert property (
    $stable(kind_code[15:12]) && $changed(kind_code[11:8]) ##1 $stable(kind_code[15:12])
    |-> $stable(ramp_count[7:6]) && $stable(lut_mode[3]))
    else $error("rising edge decode follows falling edge code");

  chk_fall_time_const: assert property (
    fw_ramp[2] && $stable(prof_field[8:6]) |-> time_const[8:6] == $past(prof_field[8:6]))
    else $error("falling time constant not taken from profile");

  chk_fall_table: assert property (
    (kind_code[11:8] >= KIND_LUT_FIXED && kind_code[11:8] <= KIND_LUT_ADAPT_NOCORR)
    |=> lut_index[5:4] == $past(prof_field[7:6]) && time_const[8:6] == 3'h0)
    else $error("falling table index not taken from profile");

  chk_rise_time_const: assert property (
    (kind_code[7:4] >= KIND_RAMP_ONE && kind_code[7:4] <= KIND_RAMP_THREE)
    |=> time_const[5:3] == $past(prof_field[5:3]) && lut_index[3:2] == 2'h0)
    else $error("rising time constant not taken from profile");

  chk_rise_table: assert property (
    (kind_code[15:12] >= KIND_LUT_FIXED && kind_code[15:12] <= KIND_LUT_ADAPT_NOCORR)
    |=> lut_index[7:6] == $past(prof_field[10:9]))
    else $error("rising table index not taken from profile");

  chk_residual_level: assert property (
    $changed(modulation_depth_212k) |=> residual_level_212k == $past(modulation_depth_212k))
    else $error("residual level does not follow depth register");

endmodule : tx_edge_shaping_config

`default_nettype wire

// ### core/tx_shaping_pkg.sv
/*
  constants for the type A transmit edge shaping configuration block:
  register indices, field positions, reset values, edge kind codes, states.
  assumes nothing of its surroundings.
*/
package tx_shaping_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices (byte address is four times the index)
  localparam int          ADDR_W                 = 12;
  localparam logic [7:0]  IDX_PROFILE_106K       = 8'h16;
  localparam logic [7:0]  IDX_DURATION_106K      = 8'h17;
  localparam logic [7:0]  IDX_DEPTH_212K         = 8'h18;
  localparam logic [7:0]  IDX_KIND_212K          = 8'h19;
  localparam logic [7:0]  IDX_PROFILE_212K       = 8'h1a;
  localparam logic [7:0]  IDX_STATUS             = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]  RST_PROFILE_106K       = 8'h00;
  localparam logic [7:0]  RST_DURATION_106K      = 8'h00;
  localparam logic [7:0]  RST_DEPTH_212K         = 8'h00;
  localparam logic [7:0]  RST_KIND_212K          = 8'h00;
  localparam logic [7:0]  RST_PROFILE_212K       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and writable masks
  localparam int          FALL_KIND_LSB          = 4;
  localparam int          RISE_KIND_LSB          = 0;
  localparam int          FALL_PROF_LSB          = 4;
  localparam int          RISE_PROF_LSB          = 0;
  localparam int          DUR_DOUBLE_BIT         = 7;
  localparam int          DUR_COUNT_LSB          = 0;
  localparam int          STAT_BUSY_BIT          = 7;
  localparam int          STAT_BAD_LSB           = 8;
  localparam logic [7:0]  PROFILE_MASK           = 8'h77;
  localparam logic [7:0]  DURATION_MASK          = 8'h9f;

  ////////////////////////////////////////////////////////////////////////////
  // edge kind codes
  localparam logic [3:0]  KIND_RAMP_ONE          = 4'h1;
  localparam logic [3:0]  KIND_RAMP_THREE        = 4'h3;
  localparam logic [3:0]  KIND_LUT_FIXED         = 4'h4;
  localparam logic [3:0]  KIND_LUT_ADAPT_CORR    = 4'h5;
  localparam logic [3:0]  KIND_LUT_ADAPT_NOCORR  = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  // carrier cycles per transition state
  localparam logic [1:0]  CYC_SINGLE             = 2'h1;
  localparam logic [1:0]  CYC_DOUBLE             = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // axi responses
  localparam logic [1:0]  RESP_OKAY              = 2'h0;
  localparam logic [1:0]  RESP_SLVERR            = 2'h2;

  typedef enum logic [1:0]
  {
    EDGE_FALL_106K = 2'b00,
    EDGE_RISE_106K = 2'b01,
    EDGE_FALL_212K = 2'b10,
    EDGE_RISE_212K = 2'b11
  } edge_sel_t;

  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } step_state_t;

endpackage : tx_shaping_pkg

// ### sim/tx_edge_shaping_config_tb.sv
/*
  self-checking bench for the type a edge shaping configuration block.
  assumes the package and the block's design files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module tx_edge_shaping_config_tb
  import tx_shaping_pkg::*;
;
  logic              aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb, fw_ramp, lut_mode, pa_supply_adapt, pa_supply_correct, kind_invalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [7:0]        edge_kind_106k, ramp_count, lut_index, residual_level_212k;
  logic              type_a_212k_rate, edge_start, carrier_tick, edge_busy, edge_done;
  logic [11:0]       time_const;
  logic [4:0]        edge_state;
  int                fails, comparisons, cycles;

  tx_edge_shaping_config uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .edge_kind_106k(edge_kind_106k), .type_a_212k_rate(type_a_212k_rate),
    .edge_start(edge_start), .carrier_tick(carrier_tick), .fw_ramp(fw_ramp), .ramp_count(ramp_count),
    .time_const(time_const), .lut_mode(lut_mode), .pa_supply_adapt(pa_supply_adapt),
    .pa_supply_correct(pa_supply_correct), .lut_index(lut_index), .kind_invalid(kind_invalid),
    .residual_level_212k(residual_level_212k), .edge_busy(edge_busy), .edge_state(edge_state),
    .edge_done(edge_done));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction : ba

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= 4'h1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_read

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [7:0] idx [5] = '{IDX_PROFILE_106K, IDX_DURATION_106K, IDX_DEPTH_212K, IDX_KIND_212K, IDX_PROFILE_212K};
    logic [7:0] msk [5] = '{PROFILE_MASK, DURATION_MASK, 8'hff, 8'hff, PROFILE_MASK};
    for (int i = 0; i < 5; i++) axi_read(ba(idx[i]), 32'h00000000, RESP_OKAY);
    for (int i = 0; i < 5; i++) axi_write(ba(idx[i]), 8'hff, RESP_OKAY);
    for (int i = 0; i < 5; i++) axi_read(ba(idx[i]), 32'(msk[i]), RESP_OKAY);
    axi_read(12'h0fc, 32'h00000000, RESP_SLVERR);
    axi_write(ba(IDX_STATUS), 8'h5a, RESP_SLVERR);
    axi_write(ba(IDX_DEPTH_212K), 8'ha5, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("residual_level_212k", 32'h000000a5, 32'(residual_level_212k));
    $display("test regs done");
  endtask : test_regs

  task automatic chk_lane(input int e, input logic [3:0] c, input logic [2:0] p);
    logic fw, lt;
    fw = (c >= 4'h1) && (c <= 4'h3);
    lt = (c >= 4'h4) && (c <= 4'h6);
    chk("fw_ramp", 32'(fw), 32'(fw_ramp[e]));
    chk("ramp_count", fw ? 32'(c[1:0]) : 32'h0, 32'(ramp_count[2*e+:2]));
    chk("lut_mode", 32'(lt), 32'(lut_mode[e]));
    chk("pa_supply_adapt", 32'(c == 4'h5 || c == 4'h6), 32'(pa_supply_adapt[e]));
    chk("pa_supply_correct", 32'(c == 4'h5), 32'(pa_supply_correct[e]));
    chk("time_const", fw ? 32'(p) : 32'h0, 32'(time_const[3*e+:3]));
    chk("lut_index", lt ? 32'(p[1:0]) : 32'h0, 32'(lut_index[2*e+:2]));
    chk("kind_invalid", 32'(!(fw || lt)), 32'(kind_invalid[e]));
  endtask : chk_lane

  task automatic test_kinds();
    logic [3:0] c;
    axi_write(ba(IDX_PROFILE_106K), 8'h26, RESP_OKAY);
    axi_write(ba(IDX_PROFILE_212K), 8'h53, RESP_OKAY);
    for (int i = 0; i < 8; i++)
    begin
      c = 4'(i);
      axi_write(ba(IDX_KIND_212K), {c, 4'(7 - i)}, RESP_OKAY);
      edge_kind_106k <= {4'(7 - i), c};
      repeat (3) @(posedge aclk);
      chk_lane(0, 4'(7 - i), 3'h2);
      chk_lane(1, c, 3'h6);
      chk_lane(2, c, 3'h5);
      chk_lane(3, 4'(7 - i), 3'h3);
    end
    // only the falling nibble moves: rising lane must hold still
    axi_write(ba(IDX_KIND_212K), 8'h24, RESP_OKAY);
    axi_write(ba(IDX_KIND_212K), 8'h64, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk_lane(2, 4'h6, 3'h5);
    chk_lane(3, 4'h4, 3'h3);
    $display("test kinds done");
  endtask : test_kinds

  task automatic run_edge(input logic [7:0] dur, input int exp_ticks);
    int n;
    n = 0;
    axi_write(ba(IDX_DURATION_106K), dur, RESP_OKAY);
    @(posedge aclk);
    edge_start <= 1'b1;
    @(posedge aclk);
    edge_start <= 1'b0;
    for (int k = 0; k < 60; k++)
    begin
      @(posedge aclk);
      if (edge_done) break;
      if (k == 0) chk("edge_busy", 32'h1, 32'(edge_busy));
      if (carrier_tick) n++;
      carrier_tick <= (k % 2 == 0);
      edge_start   <= (k == 4);
    end
    carrier_tick <= 1'b0;
    edge_start   <= 1'b0;
    chk("edge_done", 32'h1, 32'(edge_done));
    chk("ticks", 32'(exp_ticks), 32'(n));
    chk("edge_state", 32'(dur[4:0] - 5'h01), 32'(edge_state));
  endtask : run_edge

  task automatic test_stepper();
    run_edge(8'he3, 6);
    run_edge(8'h02, 2);
    // status: 106k lanes hold codes 0 and 7, last walk ended on state 1
    axi_read(ba(IDX_STATUS), 32'h00000301, RESP_OKAY);
    axi_write(ba(IDX_DURATION_106K), 8'h80, RESP_OKAY);
    edge_start <= 1'b1;
    @(posedge aclk);
    edge_start <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("edge_busy", 32'h0, 32'(edge_busy));
    $display("test stepper done");
  endtask : test_stepper

  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, edge_kind_106k} = '0;
    {type_a_212k_rate, edge_start, carrier_tick, fails, comparisons, cycles} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_kinds();
    test_stepper();
    tally_and_finish();
  end
endmodule : tx_edge_shaping_config_tb

`default_nettype wire
